// ==== bench/front_end_trigger_routing_tb_top.sv ====
// self-checking bench for the front end trigger routing register bank
`default_nettype none
module front_end_trigger_routing_tb_top;
  import fe_trigger_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, fs, oa, ob, nl;
  logic        tag0, tag1 = 1'b0, tag2 = 1'b0;
  logic [11:0] paddr, samp;
  logic [31:0] pwdata, prdata;
  logic [18:0] stim;
  logic [3:0]  pfs, poa, pob, psm;
  logic [2:0]  pnl, smp;
  logic [13:0] mux;
  logic [6:0]  q[$];
  int unsigned seed = 53792;
  int          checks, mismatches;

  pwm_event_model i_model (.pclk(pclk), .presetn(presetn), .stim(stim), .frame_sync(pfs),
    .outa(poa), .outb(pob), .sample(psm), .nonlinear(pnl));
  front_end_trigger_routing #(.PWM_COUNT(4)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_frame_sync(pfs),
    .pwm_outa_trigger(poa), .pwm_outb_trigger(pob), .pwm_sample_trigger(psm),
    .filter_nonlinear(pnl), .frontend2_frame_sync(fs), .frontend2_outa_trigger(oa),
    .frontend2_outb_trigger(ob), .frontend_sample_trigger(smp), .gain_shift_nonlinear(nl));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // one apb transfer; read data and error taken at the pready edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] er, input logic ee);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for the answer; only the watchdog ends a wait that never ends
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    chk({31'h0, pready}, 32'h1);
    if (!wr) chk(prdata, er);
    chk({31'h0, pslverr}, {31'h0, ee});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // random events; expected routing noted per cycle from the shadow registers
  task automatic run_events(input int n);
    logic [18:0] s;
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      s = 19'(xs());
      stim <= s;
      tag0 <= 1'b1;
      q.push_back({|(s[3:0] & mux[11:8]), |(s[7:4] & mux[3:0]), |(s[11:8] & mux[7:4]),
        |(s[15:12] & samp[11:8]), |(s[15:12] & samp[7:4]), |(s[15:12] & samp[3:0]),
        mux[13:12] == 2'h3 ? 1'b0 : s[16 + mux[13:12]]});
    end
    @(posedge pclk);
    tag0 <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // marks which cycles carry a note: model plus design give two edges
  always @(posedge pclk) begin
    tag1 <= tag0;
    tag2 <= tag1;
  end

  // monitor takes the oldest note whenever a routed result is due
  always @(negedge pclk) begin
    if (tag2 === 1'b1) chk({25'h0, fs, oa, ob, smp, nl}, {25'h0, q.pop_front()});
  end

  initial begin
    #80000;
    mismatches++;
    stop_test();
  end

  // main sequence: reset values, refusal, random routing, second reset
  initial begin
    {presetn, psel, penable, pwrite, tag0} = 5'h00;
    {paddr, pwdata, stim} = 63'h0;
    mux = FE2_MUX_RESET;
    samp = SAMPLE_ROUTE_RESET;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'h0, FE2_MUX_ADDR, 32'h0, 32'h2000, 1'h0);
    apb(1'h0, SAMPLE_ROUTE_ADDR, 32'h0, 32'h0, 1'h0);
    run_events(12);
    apb(1'h1, 12'h008, 32'hFFFFFFFF, 32'h0, 1'h1);
    apb(1'h0, 12'h008, 32'h0, 32'h0, 1'h1);
    apb(1'h0, FE2_MUX_ADDR, 32'h0, 32'h2000, 1'h0);
    for (int i = 0; i < 8; i++) begin
      // first pass sets every enable so several events meet at one output
      mux = (i == 0) ? 14'h0FFF : {i[1:0], 12'(xs())};
      samp = (i == 0) ? 12'hFFF : 12'(xs());
      apb(1'h1, FE2_MUX_ADDR, {18'(xs()), mux}, 32'h0, 1'h0);
      apb(1'h1, SAMPLE_ROUTE_ADDR, {20'(xs()), samp}, 32'h0, 1'h0);
      apb(1'h0, FE2_MUX_ADDR, 32'h0, {18'h0, mux}, 1'h0);
      apb(1'h0, SAMPLE_ROUTE_ADDR, 32'h0, {20'h0, samp}, 1'h0);
      run_events(16);
    end
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    mux = FE2_MUX_RESET;
    samp = SAMPLE_ROUTE_RESET;
    apb(1'h0, FE2_MUX_ADDR, 32'h0, 32'h2000, 1'h0);
    apb(1'h0, SAMPLE_ROUTE_ADDR, 32'h0, 32'h0, 1'h0);
    run_events(8);
    stop_test();
  end
endmodule
`default_nettype wire

// ==== bench/pwm_event_model.sv ====
// behavioural pwm generators and filters feeding the routing block
`default_nettype none
module pwm_event_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [18:0] stim,
  output var  logic [3:0]  frame_sync,
  output var  logic [3:0]  outa,
  output var  logic [3:0]  outb,
  output var  logic [3:0]  sample,
  output var  logic [2:0]  nonlinear
);
  timeunit 1ns;
  timeprecision 100ps;
  // events leave one edge after the bench asks; quiet while in reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {nonlinear, sample, outb, outa, frame_sync} <= 19'h0;
    end else begin
      {nonlinear, sample, outb, outa, frame_sync} <= stim;
    end
  end
endmodule
`default_nettype wire

// ==== inc/fe_trigger_pkg.sv ====
// constants for the front end trigger routing register bank
`default_nettype none
package fe_trigger_pkg;
  // register byte addresses on the apb bus
  localparam logic [11:0] FE2_MUX_ADDR       = 12'h000;
  localparam logic [11:0] SAMPLE_ROUTE_ADDR  = 12'h004;
  // register widths
  localparam int          FE2_MUX_WIDTH      = 14;
  localparam int          SAMPLE_ROUTE_WIDTH = 12;
  // front end two mux field positions
  localparam int          NONLINEAR_SOURCE_SELECT_LSB         = 12;
  localparam int          FRAME_SYNC_LSB     = 8;
  localparam int          OUTB_LSB           = 4;
  localparam int          OUTA_LSB           = 0;
  // sample trigger routing field positions, one nibble per front end
  localparam int          FE0_SAMPLE_LSB     = 0;
  localparam int          FE1_SAMPLE_LSB     = 4;
  localparam int          FE2_SAMPLE_LSB     = 8;
  // nonlinear source encodings
  localparam logic [1:0]  NL_FILTER0         = 2'h0;
  localparam logic [1:0]  NL_FILTER1         = 2'h1;
  localparam logic [1:0]  NL_FILTER2         = 2'h2;
  // reset values
  localparam logic [13:0] FE2_MUX_RESET      = 14'h2000;
  localparam logic [11:0] SAMPLE_ROUTE_RESET = 12'h000;
endpackage
`default_nettype wire

// ==== verilog/front_end_trigger_routing.sv ====
// apb register bank that routes pwm generator events to the front end controls
//
// Implementation choices: the APB register port and the address map.
`default_nettype none

module front_end_trigger_routing
  import fe_trigger_pkg::*;
#(
  parameter int PWM_COUNT = 4
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output var  logic [31:0]          prdata,
  output var  logic                 pready,
  output var  logic                 pslverr,
  input  wire logic [PWM_COUNT-1:0] pwm_frame_sync,
  input  wire logic [PWM_COUNT-1:0] pwm_outa_trigger,
  input  wire logic [PWM_COUNT-1:0] pwm_outb_trigger,
  input  wire logic [PWM_COUNT-1:0] pwm_sample_trigger,
  input  wire logic [2:0]           filter_nonlinear,
  output var  logic                 frontend2_frame_sync,
  output var  logic                 frontend2_outa_trigger,
  output var  logic                 frontend2_outb_trigger,
  output var  logic [2:0]           frontend_sample_trigger,
  output var  logic                 gain_shift_nonlinear
);

  // whole module state
  typedef struct packed {
    logic [13:0] fe2_mux;
    logic [11:0] sample_route;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
    logic        frame_sync;
    logic        outa;
    logic        outb;
    logic [2:0]  sample;
    logic        nonlinear;
  } state_t;

  state_t st;
  state_t next_st;

  // OR of all events whose route enable is set
  function automatic logic route_any(input logic [PWM_COUNT-1:0] events,
                                     input logic [PWM_COUNT-1:0] enables);
    route_any = |(events & enables);
  endfunction

  // nonlinear result of the selected filter, code 3 gives none
  function automatic logic pick_nonlinear(input logic [1:0] sel,
                                          input logic [2:0] results);
    case (sel)
      NL_FILTER0: pick_nonlinear = results[0];
      NL_FILTER1: pick_nonlinear = results[1];
      NL_FILTER2: pick_nonlinear = results[2];
      default:    pick_nonlinear = 1'b0;
    endcase
  endfunction

  logic setup_phase;
  logic access_done;
  logic hit_mux;
  logic hit_sample;

  // apb phase and address decode
  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & st.ready;
  assign hit_mux     = (paddr == FE2_MUX_ADDR);
  assign hit_sample  = (paddr == SAMPLE_ROUTE_ADDR);

  // next state: bus slave, register writes and event routing
  always_comb begin
    next_st = st;
    // answer one cycle after setup, so every access has no wait state
    next_st.ready  = setup_phase;
    next_st.slverr = setup_phase & ~(hit_mux | hit_sample);
    if (setup_phase) begin
      if (hit_mux) begin
        next_st.rdata = {18'h0, st.fe2_mux};
      end else if (hit_sample) begin
        next_st.rdata = {20'h00000, st.sample_route};
      end else begin
        next_st.rdata = 32'h00000000;
      end
    end
    // writes take effect only at the completing edge; unmapped writes drop
    if (access_done && pwrite && hit_mux) begin
      next_st.fe2_mux = pwdata[FE2_MUX_WIDTH-1:0];
    end
    if (access_done && pwrite && hit_sample) begin
      next_st.sample_route = pwdata[SAMPLE_ROUTE_WIDTH-1:0];
    end
    // event routing to front end control two
    next_st.frame_sync = route_any(pwm_frame_sync,
                                   st.fe2_mux[FRAME_SYNC_LSB +: PWM_COUNT]);
    next_st.outb = route_any(pwm_outb_trigger, st.fe2_mux[OUTB_LSB +: PWM_COUNT]);
    next_st.outa = route_any(pwm_outa_trigger, st.fe2_mux[OUTA_LSB +: PWM_COUNT]);
    // sample triggers, one nibble of enables per front end
    next_st.sample[2] = route_any(pwm_sample_trigger,
                                  st.sample_route[FE2_SAMPLE_LSB +: PWM_COUNT]);
    next_st.sample[1] = route_any(pwm_sample_trigger,
                                  st.sample_route[FE1_SAMPLE_LSB +: PWM_COUNT]);
    next_st.sample[0] = route_any(pwm_sample_trigger,
                                  st.sample_route[FE0_SAMPLE_LSB +: PWM_COUNT]);
    // nonlinear source for automatic gain shifting
    next_st.nonlinear = pick_nonlinear(st.fe2_mux[NONLINEAR_SOURCE_SELECT_LSB +: 2], filter_nonlinear);
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st              <= '0;
      st.fe2_mux      <= FE2_MUX_RESET;
      st.sample_route <= SAMPLE_ROUTE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign prdata                  = st.rdata;
  assign pready                  = st.ready;
  assign pslverr                 = st.slverr;
  assign frontend2_frame_sync    = st.frame_sync;
  assign frontend2_outa_trigger  = st.outa;
  assign frontend2_outb_trigger  = st.outb;
  assign frontend_sample_trigger = st.sample;
  assign gain_shift_nonlinear    = st.nonlinear;

  // checks on routing, reset values and mux register writes
  a_mux_reset_value: assert property (@(posedge pclk)
    $rose(presetn) |-> st.fe2_mux == FE2_MUX_RESET)
    else $error("mux register not at reset value");

  a_sample_reset_zero: assert property (@(posedge pclk)
    $rose(presetn) |-> (st.sample_route == SAMPLE_ROUTE_RESET && frontend_sample_trigger == 3'h0))
    else $error("sample routing not clear after reset");

  a_nonlinear_pick: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (st.fe2_mux[13:12] != 2'h3) ##0 $stable(st.fe2_mux) |=>
      gain_shift_nonlinear == $past(filter_nonlinear[st.fe2_mux[13:12]]))
    else $error("nonlinear result from wrong filter");

  a_frame_sync_route: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 1'b1 |=> frontend2_frame_sync == |($past(pwm_frame_sync) & $past(st.fe2_mux[11:8])))
    else $error("frame sync routing wrong");

  a_outb_route: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 1'b1 |=> frontend2_outb_trigger == |($past(pwm_outb_trigger) & $past(st.fe2_mux[7:4])))
    else $error("b trigger routing wrong");

  a_outa_route: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 1'b1 |=> frontend2_outa_trigger == |($past(pwm_outa_trigger) & $past(st.fe2_mux[3:0])))
    else $error("a trigger routing wrong");

  a_fe2_sample_route: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 1'b1 |=> frontend_sample_trigger[2] ==
      |($past(pwm_sample_trigger) & $past(st.sample_route[11:8])))
    else $error("front end 2 sample routing wrong");

  a_fe1_sample_route: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 1'b1 |=> frontend_sample_trigger[1] ==
      |($past(pwm_sample_trigger) & $past(st.sample_route[7:4])))
    else $error("front end 1 sample routing wrong");

  a_fe0_sample_route: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 1'b1 |=> frontend_sample_trigger[0] ==
      |($past(pwm_sample_trigger) & $past(st.sample_route[3:0])))
    else $error("front end 0 sample routing wrong");

  a_or_combine: assert property (@(posedge pclk) disable iff (!presetn)
    (st.sample_route[11:8] == 4'hF && pwm_sample_trigger != 4'h0 &&
     $stable(st.sample_route)) |=> frontend_sample_trigger[2])
    else $error("enabled sample triggers not combined");

  a_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
    (access_done && pwrite && hit_mux) |=> st.fe2_mux == $past(pwdata[13:0]))
    else $error("mux register write lost");

  // a setup phase is answered in the very next cycle
  a_ready_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
    setup_phase |=> pready)
    else $error("setup phase not answered");

  // ready is a single cycle pulse per transfer
  a_ready_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held past one cycle");

  // ready never comes without a setup phase before it
  a_ready_needs_setup: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> $past(setup_phase))
    else $error("ready without setup phase");

  // an unmapped address is refused with an error
  a_err_on_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_phase && !hit_mux && !hit_sample) |=> pslverr)
    else $error("unmapped access not refused");

  // mapped addresses complete without error
  a_no_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_phase && (hit_mux || hit_sample)) |=> !pslverr)
    else $error("mapped access flagged as error");

  // the error flag only stands together with ready
  a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error flag without ready");

  // the error flag stays low outside an answer
  a_err_idle_low: assert property (@(posedge pclk) disable iff (!presetn)
    !setup_phase |=> !pslverr)
    else $error("error flag raised while idle");

  // mux register read returns the stored word
  a_read_mux_word: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_phase && hit_mux) |=> prdata == {18'h0, $past(st.fe2_mux)})
    else $error("mux register read data wrong");

  // sample routing read returns the stored word
  a_read_sample_word: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_phase && hit_sample) |=> prdata == {20'h0, $past(st.sample_route)})
    else $error("sample routing read data wrong");

  // unmapped reads give zero
  a_unmapped_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_phase && !hit_mux && !hit_sample) |=> prdata == 32'h0)
    else $error("unmapped read not zero");

  // bits above the widest register always read zero
  a_upper_bits_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> prdata[31:14] == 18'h0)
    else $error("unused read bits not zero");

  // a sample routing write lands at the completing edge
  a_sample_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
    (access_done && pwrite && hit_sample) |=> st.sample_route == $past(pwdata[11:0]))
    else $error("sample routing write lost");

  // writes to unmapped addresses leave both registers alone
  a_unmapped_write_drop: assert property (@(posedge pclk) disable iff (!presetn)
    (access_done && pwrite && !hit_mux && !hit_sample) |=> $stable({st.fe2_mux, st.sample_route}))
    else $error("unmapped write changed a register");

  // reads leave both registers untouched
  a_read_keeps_regs: assert property (@(posedge pclk) disable iff (!presetn)
    (access_done && !pwrite) |=> $stable({st.fe2_mux, st.sample_route}))
    else $error("read changed a register");

  // registers change only at a completing write
  a_no_stray_write: assert property (@(posedge pclk) disable iff (!presetn)
    !access_done |=> $stable({st.fe2_mux, st.sample_route}))
    else $error("register changed without a write");

  // a cleared frame sync nibble blocks every generator
  a_frame_sync_blocked: assert property (@(posedge pclk) disable iff (!presetn)
    (st.fe2_mux[11:8] == 4'h0) |=> !frontend2_frame_sync)
    else $error("blocked frame sync passed");

  // a cleared b trigger nibble blocks every generator
  a_outb_blocked: assert property (@(posedge pclk) disable iff (!presetn)
    (st.fe2_mux[7:4] == 4'h0) |=> !frontend2_outb_trigger)
    else $error("blocked b trigger passed");

  // a cleared a trigger nibble blocks every generator
  a_outa_blocked: assert property (@(posedge pclk) disable iff (!presetn)
    (st.fe2_mux[3:0] == 4'h0) |=> !frontend2_outa_trigger)
    else $error("blocked a trigger passed");

  // no sample enable for front end 2 blocks its trigger
  a_fe2_sample_blocked: assert property (@(posedge pclk) disable iff (!presetn)
    (st.sample_route[11:8] == 4'h0) |=> !frontend_sample_trigger[2])
    else $error("blocked front end 2 sample passed");

  // no sample enable for front end 1 blocks its trigger
  a_fe1_sample_blocked: assert property (@(posedge pclk) disable iff (!presetn)
    (st.sample_route[7:4] == 4'h0) |=> !frontend_sample_trigger[1])
    else $error("blocked front end 1 sample passed");

  // no sample enable for front end 0 blocks its trigger
  a_fe0_sample_blocked: assert property (@(posedge pclk) disable iff (!presetn)
    (st.sample_route[3:0] == 4'h0) |=> !frontend_sample_trigger[0])
    else $error("blocked front end 0 sample passed");

  // no pwm event in means no front end two trigger out
  a_quiet_pwm_events: assert property (@(posedge pclk) disable iff (!presetn)
    (pwm_frame_sync == '0 && pwm_outa_trigger == '0 && pwm_outb_trigger == '0) |=>
      (!frontend2_frame_sync && !frontend2_outa_trigger && !frontend2_outb_trigger))
    else $error("trigger out without event in");

  // no sample trigger in means no sample trigger out
  a_quiet_sample_events: assert property (@(posedge pclk) disable iff (!presetn)
    (pwm_sample_trigger == '0) |=> frontend_sample_trigger == 3'h0)
    else $error("sample trigger out without event in");

  // select code three routes no filter
  a_nonlinear_none: assert property (@(posedge pclk) disable iff (!presetn)
    (st.fe2_mux[13:12] == 2'h3) |=> !gain_shift_nonlinear)
    else $error("nonlinear result on unused select");

  // all frame sync enables set: any frame sync passes
  a_or_frame_sync: assert property (@(posedge pclk) disable iff (!presetn)
    (st.fe2_mux[11:8] == 4'hF && pwm_frame_sync != '0) |=> frontend2_frame_sync)
    else $error("enabled frame syncs not combined");

  // all b trigger enables set: any b trigger passes
  a_or_outb: assert property (@(posedge pclk) disable iff (!presetn)
    (st.fe2_mux[7:4] == 4'hF && pwm_outb_trigger != '0) |=> frontend2_outb_trigger)
    else $error("enabled b triggers not combined");

  // all a trigger enables set: any a trigger passes
  a_or_outa: assert property (@(posedge pclk) disable iff (!presetn)
    (st.fe2_mux[3:0] == 4'hF && pwm_outa_trigger != '0) |=> frontend2_outa_trigger)
    else $error("enabled a triggers not combined");

  // all front end 1 sample enables set: any sample trigger passes
  a_or_fe1_sample: assert property (@(posedge pclk) disable iff (!presetn)
    (st.sample_route[7:4] == 4'hF && pwm_sample_trigger != '0) |=> frontend_sample_trigger[1])
    else $error("front end 1 samples not combined");

  // all front end 0 sample enables set: any sample trigger passes
  a_or_fe0_sample: assert property (@(posedge pclk) disable iff (!presetn)
    (st.sample_route[3:0] == 4'hF && pwm_sample_trigger != '0) |=> frontend_sample_trigger[0])
    else $error("front end 0 samples not combined");

  // outputs stay low while reset is held
  a_reset_outputs_low: assert property (@(posedge pclk)
    (!presetn ##1 !presetn) |-> (prdata == 32'h0 && !pready && !pslverr &&
      !frontend2_frame_sync && !frontend2_outa_trigger && !frontend2_outb_trigger &&
      frontend_sample_trigger == 3'h0 && !gain_shift_nonlinear))
    else $error("outputs not low during reset");

endmodule
`default_nettype wire
